/* dv/drive_start_stop_control_tb_top.sv */
// self-checking bench for the drive start/stop control
// assumes dssc_pkg and the terminal model are compiled before it
module drive_start_stop_control_tb_top
    import dssc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // signals
    // ****************************************
    logic        clk_in  = 1'b0;
    logic        srst_in = 1'b1;
    dssc_term_t  term_w;                 // terminal levels from the model
    dssc_comm_t  comm_w;                 // remote master levels
    logic        jmp  = 1'b1;            // enable jumper fitted
    logic [2:0]  sch  = SCH_TWO_LINE;    // start scheme
    logic [3:0]  meth = 4'h4;            // ramp without fault clear
    logic [1:0]  t3s  = T3_DEFAULT;      // third terminal use
    logic [15:0] lo   = 16'h0000;        // lowest frequency
    logic [15:0] hi   = 16'h1770;        // highest frequency
    logic [9:0]  npf  = 10'h03C;         // nameplate hertz
    logic [11:0] npv  = 12'h014;         // nameplate volts
    logic [15:0] ols  = 16'h0064;        // overload current setting
    logic [15:0] cur  = 16'h0000;        // motor current
    logic [15:0] fcmd = 16'h0BB8;        // frequency command
    logic        flt_in = 1'b0;          // fault pulse
    logic        running, reverse, ready, flt, olf;
    dssc_stop_t  kind;
    logic [15:0] freq;
    logic [9:0]  npf_o;
    logic [11:0] npv_o;
    int          num_errors = 0;
    int          cmp_count  = 0;

    // free-running 100 MHz clock
    initial
    begin
        forever #5 clk_in = ~clk_in;
    end

    dssc_term_model partner_u (.clk_in(clk_in), .term_out(term_w), .comm_out(comm_w));

    dssc_control #(.OL_CYCLES(100)) dut_u (
        .clk_in(clk_in), .srst_in(srst_in), .term_in(term_w), .comm_in(comm_w),
        .hardware_enable_jumper_in(jmp), .start_scheme_select_in(sch),
        .stop_method_select_in(meth), .third_terminal_function_select_in(t3s),
        .lowest_frequency_setting_in(lo), .highest_frequency_setting_in(hi),
        .nameplate_frequency_setting_in(npf), .nameplate_voltage_setting_in(npv),
        .drive_rated_volts_in(12'h1E0), .overload_current_setting_in(ols),
        .motor_current_in(cur), .freq_command_in(fcmd), .fault_in(flt_in),
        .running_out(running), .reverse_out(reverse), .ready_out(ready),
        .stop_kind_out(kind), .fault_active_out(flt),
        .motor_overload_fault_out(olf), .freq_out(freq),
        .nameplate_freq_out(npf_o), .nameplate_volts_out(npv_o));

    // ****************************************
    // tasks
    // ****************************************
    // compare one value and count it
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // set terminals, watch four cycles, check run state and stop kind
    task automatic act(input logic s, r, t, e, input dssc_stop_t k);
        dssc_stop_t seen;
        seen = STOP_NONE_T;
        partner_u.put_term(s, r, t);
        repeat (4)
        begin
            @(negedge clk_in);
            if (kind !== STOP_NONE_T)
                seen = kind;
        end
        check("running", {15'h0000, e}, {15'h0000, running});
        if (k != STOP_NONE_T)
            check("stop kind", {14'h0000, k}, {14'h0000, seen});
    endtask

    // new scheme only while stopped
    task automatic setsch(input logic [2:0] s);
        @(negedge clk_in);
        sch = s;
        tick(2);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // cuts a hang short
    initial
    begin
        repeat (20000) @(posedge clk_in);
        num_errors++;
        end_of_test();
    end

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        partner_u.put_term(1'b1, 1'b1, 1'b0);
        tick(15);
        srst_in = 1'b0;
        check("np hz", 16'h003C, {6'h00, npf_o});
        act(1, 1, 0, 0, STOP_NONE_T);
        act(1, 0, 0, 0, STOP_NONE_T);
        act(1, 1, 0, 1, STOP_NONE_T);
        act(0, 1, 0, 0, STOP_BY_COAST);
        act(1, 1, 0, 0, STOP_NONE_T);
        act(0, 0, 0, 0, STOP_NONE_T);
        act(0, 1, 0, 0, STOP_NONE_T);
        act(1, 0, 0, 0, STOP_NONE_T);
        act(1, 0, 1, 1, STOP_NONE_T);
        check("reverse", 16'h0001, {15'h0000, reverse});
        act(1, 0, 0, 0, STOP_BY_RAMP);
        t3s = T3_NONE;
        act(1, 0, 1, 0, STOP_NONE_T);
        act(1, 0, 0, 0, STOP_NONE_T);
        t3s = T3_DEFAULT;
        $display("test two_line done");
        setsch(SCH_LEVEL);
        act(1, 1, 0, 1, STOP_NONE_T);
        act(0, 1, 0, 0, STOP_BY_COAST);
        act(1, 1, 0, 1, STOP_NONE_T);
        act(1, 0, 0, 0, STOP_NONE_T);
        $display("test level done");
        setsch(SCH_THREE_LINE);
        act(1, 1, 1, 1, STOP_NONE_T);
        check("reverse", 16'h0001, {15'h0000, reverse});
        act(0, 1, 1, 0, STOP_BY_RAMP);
        act(1, 0, 0, 0, STOP_NONE_T);
        jmp = 1'b0;
        act(1, 1, 0, 1, STOP_NONE_T);
        act(0, 1, 0, 0, STOP_BY_COAST);
        act(1, 0, 0, 0, STOP_NONE_T);
        jmp = 1'b1;
        meth = 4'h6;
        act(1, 1, 0, 1, STOP_NONE_T);
        act(0, 0, 0, 0, STOP_BY_DC);
        meth = 4'h9;
        act(1, 1, 0, 1, STOP_NONE_T);
        act(0, 0, 0, 0, STOP_BY_RAMP);
        meth = 4'h4;
        $display("test three_line done");
        setsch(SCH_MOMENTARY);
        partner_u.put_term(1'b1, 1'b0, 1'b1);
        act(1, 0, 0, 1, STOP_NONE_T);
        check("reverse", 16'h0001, {15'h0000, reverse});
        act(0, 0, 0, 0, STOP_BY_COAST);
        partner_u.put_term(1'b1, 1'b1, 1'b0);
        act(1, 0, 0, 1, STOP_NONE_T);
        check("reverse", 16'h0000, {15'h0000, reverse});
        act(0, 0, 0, 0, STOP_BY_COAST);
        $display("test momentary done");
        setsch(SCH_FAST);
        check("ready", 16'h0001, {15'h0000, ready});
        act(1, 1, 0, 1, STOP_NONE_T);
        act(0, 1, 0, 0, STOP_BY_COAST);
        act(1, 0, 0, 0, STOP_NONE_T);
        $display("test fast done");
        setsch(SCH_COMM);
        check("ready", 16'h0000, {15'h0000, ready});
        partner_u.put_comm(1'b1, 1'b0);
        act(1, 0, 0, 1, STOP_NONE_T);
        act(0, 0, 0, 0, STOP_BY_COAST);
        partner_u.put_comm(1'b0, 1'b0);
        act(1, 0, 0, 0, STOP_NONE_T);
        $display("test comm done");
        setsch(SCH_TWO_LINE);
        lo = 16'h03E8;
        hi = 16'h1388;
        fcmd = 16'h2710;
        act(1, 1, 0, 1, STOP_NONE_T);
        check("freq", 16'h1388, freq);
        fcmd = 16'h0064;
        tick(3);
        check("freq", 16'h03E8, freq);
        sch = SCH_COMM;
        act(1, 0, 0, 0, STOP_BY_RAMP);
        check("freq", 16'h0000, freq);
        $display("test limits done");
        setsch(SCH_THREE_LINE);
        meth = STOP_COAST;
        flt_in = 1'b1;
        tick(1);
        flt_in = 1'b0;
        act(1, 1, 0, 0, STOP_NONE_T);
        act(0, 0, 0, 0, STOP_NONE_T);
        act(1, 0, 0, 0, STOP_NONE_T);
        check("fault", 16'h0001, {15'h0000, flt});
        meth = STOP_COAST_CF;
        act(0, 0, 0, 0, STOP_NONE_T);
        act(1, 0, 0, 0, STOP_NONE_T);
        check("fault", 16'h0000, {15'h0000, flt});
        meth = 4'h4;
        $display("test fault done");
        act(1, 1, 0, 1, STOP_NONE_T);
        cur = 16'h0097;
        tick(60);
        check("overload", 16'h0000, {15'h0000, olf});
        tick(60);
        check("overload", 16'h0001, {15'h0000, olf});
        cur = 16'h0000;
        act(0, 0, 0, 0, STOP_NONE_T);
        $display("test overload done");
        npf = 10'h1F5;
        tick(3);
        check("np hz", 16'h003C, {6'h00, npf_o});
        npf = 10'h00F;
        tick(3);
        check("np hz", 16'h000F, {6'h00, npf_o});
        npv = 12'h013;
        tick(3);
        check("np volts", 16'h0014, {4'h0, npv_o});
        npv = 12'h0E6;
        tick(3);
        check("np volts", 16'h00E6, {4'h0, npv_o});
        npv = 12'h1E1;
        tick(3);
        check("np volts", 16'h00E6, {4'h0, npv_o});
        $display("test nameplate done");
        end_of_test();
    end
endmodule

/* dv/dssc_term_model.sv */
// model of the control terminal block and the remote master
// assumes the bench calls its tasks; levels change at falling edges only
module dssc_term_model
    import dssc_pkg::*;
(
    input  wire logic clk_in,
    output dssc_term_t term_out,
    output dssc_comm_t comm_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // contact levels
    // ****************************************
    // stop contact closed, both run contacts open at power up
    initial
    begin
        term_out = '{stop_closed: 1'b1, run_forward_input: 1'b0, term3: 1'b0};
        comm_out = '0;
    end

    // new terminal levels, applied away from the sampling edge
    task automatic put_term(input logic s, input logic r, input logic t);
        @(negedge clk_in);
        term_out = '{stop_closed: s, run_forward_input: r, term3: t};
    endtask

    // remote start and direction levels
    task automatic put_comm(input logic st, input logic rv);
        @(negedge clk_in);
        comm_out = '{start: st, reverse: rv, stop: 1'b0};
    endtask
endmodule

/* rtl/dssc_control.sv */
// drive start/stop control: start scheme, stop method, limits, overload
// assumes terminal and comm inputs synchronous to clk_in, settings static while running
module dssc_control
    import dssc_pkg::*;
#(
    parameter longint OL_CYCLES = OL_CYC  // shorten in simulation
)(
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire dssc_term_t  term_in,
    input  wire dssc_comm_t  comm_in,
    input  wire logic        hardware_enable_jumper_in,     // 1 = fitted
    input  wire logic [2:0]  start_scheme_select_in,
    input  wire logic [3:0]  stop_method_select_in,
    input  wire logic [1:0]  third_terminal_function_select_in,
    input  wire logic [15:0] lowest_frequency_setting_in,
    input  wire logic [15:0] highest_frequency_setting_in,
    input  wire logic [9:0]  nameplate_frequency_setting_in,
    input  wire logic [11:0] nameplate_voltage_setting_in,
    input  wire logic [11:0] drive_rated_volts_in,
    input  wire logic [15:0] overload_current_setting_in,
    input  wire logic [15:0] motor_current_in,
    input  wire logic [15:0] freq_command_in,
    input  wire logic        fault_in,                      // pulse, raises a fault
    output logic             running_out,
    output logic             reverse_out,
    output logic             ready_out,
    output dssc_stop_t       stop_kind_out,
    output logic             fault_active_out,
    output logic             motor_overload_fault_out,
    output logic [15:0]      freq_out,
    output logic [9:0]       nameplate_freq_out,
    output logic [11:0]      nameplate_volts_out
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] clamp16(input logic [15:0] v, lo, hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction
    function automatic dssc_stop_t method_kind(input logic [3:0] m);
        case (m[1:0])
            // codes from the brake-control pair upward always ramp
            2'h1:    method_kind = (m >= STOP_EMB_CF) ? STOP_BY_RAMP : STOP_BY_COAST;
            2'h2,
            2'h3:    method_kind = (m >= STOP_EMB_CF) ? STOP_BY_RAMP : STOP_BY_DC;
            default: method_kind = STOP_BY_RAMP;
        endcase
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [2:0]  scheme_reg, scheme_next;      // latched scheme
    logic        run_reg, run_next;
    logic        rev_reg, rev_next;
    logic        fault_reg, fault_next;
    logic        olf_reg, olf_next;
    logic [39:0] ol_cnt_reg, ol_cnt_next;
    logic        start_prev_reg, start_prev_next;
    logic        fwd_prev_reg, fwd_prev_next;
    logic        t3_prev_reg, t3_prev_next;
    dssc_stop_t  kind_reg, kind_next;
    logic [15:0] freq_reg, freq_next;
    logic [9:0]  nph_reg, nph_next;
    logic [11:0] npv_reg, npv_next;

    // combinational terms
    logic [1:0]  t3_func;
    logic        start_lvl, start_edge, want_rev, other_stop, term_stop;
    logic        ol_over;
    logic [31:0] ol_cur_x, ol_lim_x;

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb
    begin
        // terminal 03 use: scheme default unless reassigned
        t3_func = third_terminal_function_select_in;                          // [RULE19]
        if (t3_func == T3_DEFAULT)
            t3_func = (scheme_reg == SCH_THREE_LINE) ? T3_DIRECTION : T3_RUN_REVERSE_INPUT; // [RULE3] [RULE4]
        start_lvl  = 1'b0;
        want_rev   = rev_reg;
        other_stop = 1'b0;
        case (scheme_reg)
            SCH_COMM:                                                          // [RULE8]
            begin
                start_lvl  = comm_in.start;
                want_rev   = comm_in.reverse;
                other_stop = comm_in.stop;
            end
            SCH_THREE_LINE:
            begin
                start_lvl = term_in.run_forward_input;
                want_rev  = (t3_func == T3_DIRECTION) ? term_in.term3 : 1'b0; // [RULE3]
            end
            SCH_MOMENTARY:                                                     // [RULE9]
            begin
                start_lvl = term_in.run_forward_input | (t3_func == T3_RUN_REVERSE_INPUT && term_in.term3);
                want_rev  = (t3_func == T3_RUN_REVERSE_INPUT) && term_in.term3;
            end
            default:
            begin
                start_lvl  = term_in.run_forward_input | (t3_func == T3_RUN_REVERSE_INPUT && term_in.term3);
                want_rev   = (t3_func == T3_RUN_REVERSE_INPUT) && term_in.term3;
                // releasing the maintained run input is itself a stop source
                other_stop = run_reg && !start_lvl;                            // [RULE10]
            end
        endcase
        start_edge = start_lvl &&
            !(start_prev_reg || (scheme_reg == SCH_MOMENTARY &&
              (fwd_prev_reg && term_in.run_forward_input || t3_prev_reg && term_in.term3)));
        term_stop = !term_in.stop_closed;                                      // [RULE2]

        // defaults
        scheme_next     = scheme_reg;
        run_next        = run_reg;
        rev_next        = rev_reg;
        kind_next       = STOP_NONE_T;
        fault_next      = fault_reg | fault_in | olf_reg;
        start_prev_next = start_lvl;
        fwd_prev_next   = term_in.run_forward_input;
        t3_prev_next    = term_in.term3;

        if (!run_reg)
            scheme_next = start_scheme_select_in;                              // [RULE21]
        // a new scheme reads a new start source: its held level is not an edge
        if (scheme_next != scheme_reg)
            start_prev_next = 1'b1;                                            // [RULE1]

        if (term_stop || other_stop)
        begin
            run_next = 1'b0;
            // a removed jumper makes a stop-terminal stop coast in every scheme and stop method
            if (term_stop && !hardware_enable_jumper_in)
                kind_next = STOP_BY_COAST;                                     // [RULE12]
            else if (term_stop && scheme_reg != SCH_THREE_LINE)
                kind_next = STOP_BY_COAST;  // [RULE4] [RULE5] [RULE11]
            else
                kind_next = method_kind(stop_method_select_in);                // [RULE10] [RULE3]
            // clear-fault stop codes, ignored when the fault is raised now
            if ((stop_method_select_in <= STOP_CLEAR_MAX || stop_method_select_in == STOP_EMB_CF)
                && !fault_in && !olf_reg)
                fault_next = 1'b0;                                             // [RULE20]
        end
        else if (!run_reg && !fault_reg)
        begin
            // level mode restarts on held start; others need a new edge
            if ((scheme_reg == SCH_LEVEL) ? start_lvl : start_edge)            // [RULE1] [RULE5] [RULE6]
            begin
                run_next = 1'b1;                                               // [RULE7]
                rev_next = want_rev;
            end
        end
        else if (run_reg && scheme_reg != SCH_MOMENTARY)
            rev_next = want_rev;
        if (fault_reg)
            run_next = 1'b0;

        // overload: current above 150 percent of setting for the set time
        ol_cur_x = 32'(motor_current_in) * 32'(PCT_FULL);
        ol_lim_x = 32'(overload_current_setting_in) * 32'(OL_PCT);
        ol_over  = ol_cur_x > ol_lim_x;
        olf_next    = olf_reg;
        ol_cnt_next = ol_over ? ol_cnt_reg + 40'h00_0000_0001 : 40'h00_0000_0000;
        if (ol_over && ol_cnt_reg >= 40'(OL_CYCLES - 1))
        begin
            olf_next    = 1'b1;                                                // [RULE13]
            ol_cnt_next = ol_cnt_reg;
        end
        else if (!ol_over && term_stop)
            olf_next = 1'b0;

        // frequency limits and nameplate ranges
        freq_next = run_reg ? clamp16(freq_command_in,
            clamp16(lowest_frequency_setting_in, FREQ_MIN_DEF, FREQ_LIMIT),    // [RULE14]
            clamp16(highest_frequency_setting_in, FREQ_MIN_DEF, FREQ_LIMIT))   // [RULE15]
            : FREQ_MIN_DEF;
        nph_next = (nameplate_frequency_setting_in < NP_HZ_LO ||
                    nameplate_frequency_setting_in > NP_HZ_HI) ? nph_reg
                   : nameplate_frequency_setting_in;                           // [RULE16]
        npv_next = (nameplate_voltage_setting_in < NP_VOLT_LO ||
                    nameplate_voltage_setting_in > drive_rated_volts_in) ? npv_reg
                   : nameplate_voltage_setting_in;                             // [RULE17]
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            scheme_reg     <= SCH_COMM;
            run_reg        <= 1'b0;
            rev_reg        <= 1'b0;
            fault_reg      <= 1'b0;
            olf_reg        <= 1'b0;
            ol_cnt_reg     <= 40'h00_0000_0000;
            start_prev_reg <= 1'b1;
            fwd_prev_reg   <= 1'b1;
            t3_prev_reg    <= 1'b1;
            kind_reg       <= STOP_NONE_T;
            freq_reg       <= FREQ_MIN_DEF;
            nph_reg        <= NP_HZ_DEF;
            npv_reg        <= NP_VOLT_LO;
        end
        else
        begin
            scheme_reg     <= scheme_next;
            run_reg        <= run_next;
            rev_reg        <= rev_next;
            fault_reg      <= fault_next;
            olf_reg        <= olf_next;
            ol_cnt_reg     <= ol_cnt_next;
            start_prev_reg <= start_prev_next;
            fwd_prev_reg   <= fwd_prev_next;
            t3_prev_reg    <= t3_prev_next;
            kind_reg       <= kind_next;
            freq_reg       <= freq_next;
            nph_reg        <= nph_next;
            npv_reg        <= npv_next;
        end
    end

    // outputs
    assign running_out              = run_reg;
    assign reverse_out              = rev_reg;
    assign ready_out                = (scheme_reg == SCH_FAST) && !fault_reg;  // [RULE7]
    assign stop_kind_out            = kind_reg;
    assign fault_active_out         = fault_reg;
    assign motor_overload_fault_out = olf_reg;
    assign freq_out                 = freq_reg;
    assign nameplate_freq_out       = nph_reg;
    assign nameplate_volts_out      = npv_reg;

    // ****************************************
    // assertions
    // ****************************************
    property p_stop_open_halts;
        @(posedge clk_in) disable iff (srst_in)
        !term_in.stop_closed |=> !running_out;
    endproperty
    a_stop_open_halts: assert property (p_stop_open_halts) // [RULE2]
        else $error("run continued with stop terminal open");
    property p_jumper_coast;
        @(posedge clk_in) disable iff (srst_in)
        (!term_in.stop_closed && !hardware_enable_jumper_in) |=> stop_kind_out == STOP_BY_COAST;
    endproperty
    a_jumper_coast: assert property (p_jumper_coast) // [RULE12]
        else $error("jumper removed but stop was not coast");
    property p_coast_not3;
        @(posedge clk_in) disable iff (srst_in)
        (!term_in.stop_closed && scheme_reg != SCH_THREE_LINE) |=> stop_kind_out == STOP_BY_COAST;
    endproperty
    a_coast_not3: assert property (p_coast_not3) // [RULE11]
        else $error("stop terminal did not coast");
    property p_edge_start;
        @(posedge clk_in) disable iff (srst_in)
        (!running_out && scheme_reg != SCH_LEVEL && scheme_reg != SCH_MOMENTARY
         && start_prev_reg) |=> !running_out;
    endproperty
    a_edge_start: assert property (p_edge_start) // [RULE1]
        else $error("start without a fresh edge");
    property p_scheme_hold;
        @(posedge clk_in) disable iff (srst_in)
        running_out |=> $stable(scheme_reg);
    endproperty
    a_scheme_hold: assert property (p_scheme_hold) // [RULE21]
        else $error("scheme changed while running");
    property p_freq_cap;
        @(posedge clk_in) disable iff (srst_in)
        (running_out && highest_frequency_setting_in >= lowest_frequency_setting_in
         && highest_frequency_setting_in <= FREQ_LIMIT)
        |=> freq_out <= $past(highest_frequency_setting_in);
    endproperty
    a_freq_cap: assert property (p_freq_cap) // [RULE15]
        else $error("output frequency above ceiling");
    property p_np_range;
        @(posedge clk_in) disable iff (srst_in)
        nameplate_freq_out >= NP_HZ_LO && nameplate_freq_out <= NP_HZ_HI;
    endproperty
    a_np_range: assert property (p_np_range) // [RULE16]
        else $error("nameplate frequency out of range");
    property p_fault_blocks;
        @(posedge clk_in) disable iff (srst_in)
        fault_active_out |=> !running_out;
    endproperty
    a_fault_blocks: assert property (p_fault_blocks) // [RULE20]
        else $error("ran while faulted");
    // level mode: a held start resumes as soon as the stop closes
    property p_level_restart;
        @(posedge clk_in) disable iff (srst_in)
        (scheme_reg == SCH_LEVEL && !running_out && !fault_active_out
         && term_in.stop_closed && start_lvl) |=> running_out;
    endproperty
    a_level_restart: assert property (p_level_restart) // [RULE5]
        else $error("held start did not restart in level mode");
    // a new fault wins against a clearing stop in the same cycle
    property p_fault_set;
        @(posedge clk_in) disable iff (srst_in)
        fault_in |=> fault_active_out;
    endproperty
    a_fault_set: assert property (p_fault_set) // [RULE20]
        else $error("fault pulse lost against a clearing stop");
    c_dc:    cover property (@(posedge clk_in) disable iff (srst_in) stop_kind_out == STOP_BY_DC);
    c_run:   cover property (@(posedge clk_in) disable iff (srst_in) $rose(running_out));
    c_rev:   cover property (@(posedge clk_in) disable iff (srst_in) running_out && reverse_out);
    c_ol:    cover property (@(posedge clk_in) disable iff (srst_in) $rose(motor_overload_fault_out));
endmodule

/* shared/dssc_pkg.sv */
// constants, field layouts and types for the drive start/stop control block
// assumes a single 100 MHz clock and terminal inputs already synchronous
//
// Contract
// RULE1: outside level mode, start needs fresh edge
// RULE2: stop terminal always stops, must be active
// RULE3: three-wire: stop uses mode, terminal3 is direction
// RULE4: two-wire: stop coasts, terminal3 runs reverse
// RULE5: level mode: coast, restart when start held
// RULE6: level mode: stop only while stop open
// RULE7: fast mode: ready outputs, start within 10 ms
// RULE8: comm mode default: remote starts, terminal stop coasts
// RULE9: momentary: pulse on either run input starts
// RULE10: selected stop mode governs all stop sources; code coasts the stop terminal except in three-wire with jumper fitted
// RULE11: stop terminal coasts except in three-wire
// RULE12: jumper removed: stop terminal forces coast always
// RULE13: overload fault after 150 percent for 60 s
// RULE14: lowest frequency floors output, default 0.00 Hz
// RULE15: highest frequency caps output, default 60.00 Hz
// RULE16: nameplate frequency 15 to 500 Hz, default 60
// RULE17: nameplate voltage from 20 V to rating
// RULE18: other party stops drive before changing settings
// RULE19: terminal3 function reassignable independently
// RULE20: stop codes 0-3 clear fault, 4-7 not
// RULE21: start scheme sampled only while stopped
package dssc_pkg;
    // ****************************************
    // start schemes and stop methods
    // ****************************************
    localparam logic [2:0] SCH_THREE_LINE = 3'h1;
    localparam logic [2:0] SCH_TWO_LINE   = 3'h2;
    localparam logic [2:0] SCH_LEVEL      = 3'h3;
    localparam logic [2:0] SCH_FAST       = 3'h4;
    localparam logic [2:0] SCH_COMM       = 3'h5;
    localparam logic [2:0] SCH_MOMENTARY  = 3'h6;
    localparam logic [3:0] STOP_RAMP_CF   = 4'h0;
    localparam logic [3:0] STOP_COAST_CF  = 4'h1;
    localparam logic [3:0] STOP_CLEAR_MAX = 4'h3;
    localparam logic [3:0] STOP_COAST     = 4'h5;
    localparam logic [3:0] STOP_EMB_CF    = 4'h8;
    // third terminal functions
    localparam logic [1:0] T3_DEFAULT     = 2'h0;
    localparam logic [1:0] T3_DIRECTION   = 2'h1;
    localparam logic [1:0] T3_RUN_REVERSE_INPUT     = 2'h2;
    localparam logic [1:0] T3_NONE        = 2'h3;
    // ****************************************
    // frequency limits in 0.01 Hz units, nameplate limits in Hz and V
    // ****************************************
    localparam logic [15:0] FREQ_MIN_DEF  = 16'h0000;   // 0.00 Hz
    localparam logic [15:0] FREQ_MAX_DEF  = 16'h1770;   // 60.00 Hz
    localparam logic [15:0] FREQ_LIMIT    = 16'hC350;   // 500.00 Hz
    localparam logic [9:0]  NP_HZ_LO      = 10'h00F;    // 15 Hz
    localparam logic [9:0]  NP_HZ_HI      = 10'h1F4;    // 500 Hz
    localparam logic [9:0]  NP_HZ_DEF     = 10'h03C;    // 60 Hz
    localparam logic [11:0] NP_VOLT_LO    = 12'h014;    // 20 V
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ        = 100;
    localparam int FAST_RESP_MS   = 10;
    localparam int FAST_RESP_CYC  = FAST_RESP_MS * 1000 * CLK_MHZ;
    localparam int OL_SECONDS     = 60;
    localparam longint OL_CYC     = longint'(OL_SECONDS) * 1000000 * CLK_MHZ;
    localparam int OL_PCT         = 150;
    localparam int PCT_FULL       = 100;
    // ****************************************
    // carriers
    // ****************************************
    typedef enum logic [1:0] {STOP_NONE_T, STOP_BY_COAST, STOP_BY_RAMP, STOP_BY_DC} dssc_stop_t;
    typedef struct packed
    {
        logic stop_closed;  // terminal 01, 1 = run permitted
        logic run_forward_input;      // terminal 02
        logic term3;        // terminal 03
    } dssc_term_t;
    typedef struct packed
    {
        logic start;
        logic reverse;
        logic stop;
    } dssc_comm_t;
endpackage
